//--- pkg/wdr_regs.svh
`ifndef WDR_REGS_SVH
`define WDR_REGS_SVH

// Register byte offsets on the AXI4-Lite slave
`define WDR_ADDR_W        8
`define WDR_OFF_CAUSE     8'h00
`define WDR_OFF_OPTION    8'h04
`define WDR_OFF_COUNT     8'h08

// Option register layout and its value after reset
`define WDR_OPT_W         4
`define WDR_OPT_LOCK_BIT  4
`define WDR_CFG_RESET     4'hC
`define WDR_TSEL_OFF      2'h0

// Overflow point, stored as the last count before overflow
`define WDR_CNT_W         18
`define WDR_LPO_LAST_1    18'h0001F
`define WDR_LPO_LAST_2    18'h000FF
`define WDR_LPO_LAST_3    18'h003FF
`define WDR_BUS_LAST_1    18'h01FFF
`define WDR_BUS_LAST_2    18'h0FFFF
`define WDR_BUS_LAST_3    18'h3FFFF

// Count at which the service window opens (bus clock only)
`define WDR_WIN_1         18'h01800
`define WDR_WIN_2         18'h0C000
`define WDR_WIN_3         18'h30000

// AXI response codes
`define WDR_RESP_OKAY     2'h0
`define WDR_RESP_SLVERR   2'h2

`endif

//--- pkg/wdr_pkg.sv
package wdr_pkg;

	// Watchdog configuration as held in the option register
	typedef struct packed {
		logic [1:0] timeout_select;
		logic       count_clock_select;
		logic       window_enable;
	} wdr_cfg_t;

	// One flag per reset source except the debug reset, most recent only
	typedef struct packed {
		logic por;
		logic pin;
		logic wdog;
		logic bad_opcode_rst;
		logic bad_address_rst;
		logic low_voltage_rst;
	} wdr_cause_t;

	// Reset request lines from the rest of the system
	typedef struct packed {
		logic por;
		logic pin;
		logic bad_opcode_rst;
		logic bad_address_rst;
		logic low_voltage_rst;
		logic debug_rst;
	} wdr_src_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [2:0] prot;
	} wdr_axaddr_t;

	typedef struct packed {
		logic [31:0] data;
		logic [3:0]  strb;
	} wdr_wdata_t;

	typedef struct packed {
		logic [31:0] data;
		logic [1:0]  resp;
	} wdr_rdata_t;

endpackage

//--- design/wdr_lpo_tick.sv
`timescale 1ns/1ps
`default_nettype none

// Turns the slow oscillator level into a one-cycle count enable
module wdr_lpo_tick (
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic low_power_osc,
	output logic      tick
);
	logic osc_prev_r;

	// Previous level; the oscillator is far slower than ref_clk
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			osc_prev_r <= 1'b0;
		end else begin
			osc_prev_r <= low_power_osc;
		end
	end

	// Rising edge marks one oscillator cycle
	assign tick = low_power_osc & ~osc_prev_r;
endmodule

`default_nettype wire

//--- design/wdr_watchdog.sv
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`include "wdr_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module wdr_watchdog (
	input  wire logic               ref_clk,
	input  wire logic               reset,
	input  wire logic               s_awvalid,
	output logic                    s_awready,
	input  wire wdr_pkg::wdr_axaddr_t s_aw,
	input  wire logic               s_wvalid,
	output logic                    s_wready,
	input  wire wdr_pkg::wdr_wdata_t  s_w,
	output logic                    s_bvalid,
	input  wire logic               s_bready,
	output logic [1:0]              s_bresp,
	input  wire logic               s_arvalid,
	output logic                    s_arready,
	input  wire wdr_pkg::wdr_axaddr_t s_ar,
	output logic                    s_rvalid,
	input  wire logic               s_rready,
	output wdr_pkg::wdr_rdata_t     s_r,
	input  wire logic               low_power_osc,
	input  wire logic               debug_halt,
	input  wire logic               stop_mode,
	input  wire wdr_pkg::wdr_src_t    rst_src,
	output logic                    sys_reset_req
);
	import wdr_pkg::*;

	// Last count before overflow for a clock and timeout choice
	function automatic logic [`WDR_CNT_W-1:0] last_count(input logic bus, input logic [1:0] tsel);
		case (tsel)
			2'h1:    last_count = bus ? `WDR_BUS_LAST_1 : `WDR_LPO_LAST_1;
			2'h2:    last_count = bus ? `WDR_BUS_LAST_2 : `WDR_LPO_LAST_2;
			default: last_count = bus ? `WDR_BUS_LAST_3 : `WDR_LPO_LAST_3;
		endcase
	endfunction

	// Count at which the service window opens
	function automatic logic [`WDR_CNT_W-1:0] window_open(input logic [1:0] tsel);
		case (tsel)
			2'h1:    window_open = `WDR_WIN_1;
			2'h2:    window_open = `WDR_WIN_2;
			default: window_open = `WDR_WIN_3;
		endcase
	endfunction

	wdr_cfg_t                cfg_r;
	logic                    locked_r;
	logic [`WDR_CNT_W-1:0]   cnt_r;
	logic [`WDR_CNT_W-1:0]   cnt_nxt;
	logic                    wdog_rst_r;
	wdr_cause_t              cause_r;
	wdr_cause_t              cause_nxt;
	logic                    aw_full_r;
	logic                    w_full_r;
	wdr_axaddr_t             aw_r;
	wdr_wdata_t              w_r;
	logic                    bvalid_r;
	logic [1:0]              bresp_r;
	logic                    rvalid_r;
	wdr_rdata_t              r_r;
	logic                    lpo_tick;

	wdr_lpo_tick u_lpo_tick (
		.ref_clk      (ref_clk),
		.reset        (reset),
		.low_power_osc(low_power_osc),
		.tick         (lpo_tick)
	);

	// Write channel: address and data are caught in either order
	wire aw_take = s_awvalid & s_awready;
	wire w_take  = s_wvalid & s_wready;
	wire do_wr   = aw_full_r & w_full_r & ~bvalid_r;
	wire wr_cause  = do_wr & (aw_r.addr == `WDR_OFF_CAUSE);
	wire wr_option = do_wr & (aw_r.addr == `WDR_OFF_OPTION);
	wire wr_count  = do_wr & (aw_r.addr == `WDR_OFF_COUNT);
	wire wr_mapped = wr_cause | wr_option | wr_count;
	assign s_awready = ~aw_full_r;
	assign s_wready  = ~w_full_r;
	assign s_bvalid  = bvalid_r;
	assign s_bresp   = bresp_r;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			aw_full_r <= 1'b0;
			w_full_r  <= 1'b0;
			aw_r      <= '0;
			w_r       <= '0;
		end else begin
			aw_full_r <= aw_take | (aw_full_r & ~do_wr);
			w_full_r  <= w_take | (w_full_r & ~do_wr);
			aw_r      <= aw_take ? s_aw : aw_r;
			w_r       <= w_take ? s_w : w_r;
		end
	end

	// Response; unmapped offsets answer SLVERR and change nothing
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			bvalid_r <= 1'b0;
			bresp_r  <= `WDR_RESP_OKAY;
		end else begin
			bvalid_r <= do_wr | (bvalid_r & ~s_bready);
			bresp_r  <= do_wr ? (wr_mapped ? `WDR_RESP_OKAY : `WDR_RESP_SLVERR) : bresp_r;
		end
	end

	// Read channel: one read at a time, data registered
	wire ar_take = s_arvalid & s_arready;
	wire [31:0] rd_data =
		(s_ar.addr == `WDR_OFF_CAUSE)  ? {26'h0, cause_r} :
		(s_ar.addr == `WDR_OFF_OPTION) ? {27'h0, locked_r, cfg_r} :
		(s_ar.addr == `WDR_OFF_COUNT)  ? {14'h0, cnt_r} : 32'h0;
	wire rd_mapped = (s_ar.addr == `WDR_OFF_CAUSE) | (s_ar.addr == `WDR_OFF_OPTION) |
		(s_ar.addr == `WDR_OFF_COUNT);
	assign s_arready = ~rvalid_r;
	assign s_rvalid  = rvalid_r;
	assign s_r       = r_r;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rvalid_r <= 1'b0;
			r_r      <= '0;
		end else begin
			rvalid_r <= ar_take | (rvalid_r & ~s_rready);
			r_r      <= ar_take ? {rd_data, rd_mapped ? `WDR_RESP_OKAY : `WDR_RESP_SLVERR} : r_r;
		end
	end

	// Write-once configuration; the lock keeps a runaway program from changing it
	wire cfg_first = wr_option & ~locked_r & w_r.strb[0];

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cfg_r    <= wdr_cfg_t'(`WDR_CFG_RESET);
			locked_r <= 1'b0;
		end else begin
			cfg_r    <= cfg_first ? wdr_cfg_t'(w_r.data[`WDR_OPT_W-1:0]) : cfg_r;
			locked_r <= locked_r | cfg_first;
		end
	end

	// Counting conditions decoded from the live configuration
	wire enabled   = cfg_r.timeout_select != `WDR_TSEL_OFF;
	wire on_bus    = cfg_r.count_clock_select;
	wire halted    = debug_halt | stop_mode;
	wire windowed  = cfg_r.window_enable & on_bus;
	wire [`WDR_CNT_W-1:0] last = last_count(on_bus, cfg_r.timeout_select);
	wire in_window = cnt_r >= window_open(cfg_r.timeout_select);
	wire early_svc = wr_cause & enabled & windowed & ~in_window;
	wire tick      = enabled & (on_bus ? ~halted : (lpo_tick & ~halted));
	wire overflow  = tick & (cnt_r == last);
	wire lpo_halt  = ~on_bus & halted;
	wire cnt_clr   = wr_cause | cfg_first | lpo_halt;

	// Counter next value: clear wins over counting
	always_comb begin
		if (cnt_clr | overflow) begin
			cnt_nxt = '0;
		end else if (tick) begin
			cnt_nxt = cnt_r + `WDR_CNT_W'(1);
		end else begin
			cnt_nxt = cnt_r;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// Reset request, one cycle, from overflow or an early service
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wdog_rst_r <= 1'b0;
		end else begin
			wdog_rst_r <= (overflow | early_svc) & enabled;
		end
	end
	assign sys_reset_req = wdog_rst_r;

	// Most recent cause replaces older ones; a debug reset records none.
	// Not cleared by reset, otherwise the record would never survive it.
	wire any_src = rst_src.por | rst_src.pin | rst_src.bad_opcode_rst |
		rst_src.bad_address_rst | rst_src.low_voltage_rst | rst_src.debug_rst | wdog_rst_r;

	always_comb begin
		cause_nxt = '0;
		if (rst_src.por) begin
			cause_nxt.por = 1'b1;
		end else if (rst_src.pin) begin
			cause_nxt.pin = 1'b1;
		end else if (rst_src.low_voltage_rst) begin
			cause_nxt.low_voltage_rst = 1'b1;
		end else if (rst_src.bad_opcode_rst) begin
			cause_nxt.bad_opcode_rst = 1'b1;
		end else if (rst_src.bad_address_rst) begin
			cause_nxt.bad_address_rst = 1'b1;
		end else if (wdog_rst_r) begin
			cause_nxt.wdog = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		cause_r <= any_src ? cause_nxt : cause_r;
	end

	// Checks kept beside the logic they guard
	AST_RESET_DEFAULT: assert property (@(posedge ref_clk)
		reset |=> (cfg_r == wdr_cfg_t'(`WDR_CFG_RESET)) && !locked_r && cnt_r == '0)
		else $error("watchdog default configuration wrong after reset");

	AST_SERVICE_KEEPS_CAUSE: assert property (@(posedge ref_clk) disable iff (reset)
		(wr_cause && !any_src) |=> $stable(cause_r) && cnt_r == '0)
		else $error("service write altered cause or did not clear count");

	AST_DISABLED_SILENT: assert property (@(posedge ref_clk) disable iff (reset)
		(cfg_r.timeout_select == 2'h0) [*2] |-> !sys_reset_req)
		else $error("disabled watchdog requested a reset");

	AST_LPO_STEPS: assert property (@(posedge ref_clk) disable iff (reset)
		(!on_bus && !lpo_tick && !cnt_clr) |=> $stable(cnt_r))
		else $error("counter moved without an oscillator edge");

	AST_OVERFLOW_RESET: assert property (@(posedge ref_clk) disable iff (reset)
		(tick && cnt_r == last && enabled) |=> sys_reset_req ##1 !sys_reset_req)
		else $error("overflow did not give a one-cycle reset request");

	AST_BUS_OVF_FIRST: assert property (@(posedge ref_clk) disable iff (reset)
		(on_bus && cfg_r.timeout_select == 2'h1 && cnt_r == 18'h01FFE && tick && !cnt_clr)
		|=> !sys_reset_req ##0 cnt_r == 18'h01FFF)
		else $error("bus overflow point for the shortest timeout wrong");

	AST_EARLY_SERVICE: assert property (@(posedge ref_clk) disable iff (reset)
		(wr_cause && windowed && enabled && cnt_r < window_open(cfg_r.timeout_select))
		|=> sys_reset_req)
		else $error("early service in windowed mode did not reset");

	AST_WINDOW_OK: assert property (@(posedge ref_clk) disable iff (reset)
		(wr_cause && windowed && cnt_r >= window_open(cfg_r.timeout_select) && cnt_r != last)
		|=> !sys_reset_req)
		else $error("service inside the window caused a reset");

	AST_LPO_NO_WINDOW: assert property (@(posedge ref_clk) disable iff (reset)
		(wr_cause && !on_bus && cfg_r.window_enable && !overflow) |=> !sys_reset_req)
		else $error("window applied on the slow oscillator");

	AST_WRITE_ONCE: assert property (@(posedge ref_clk) disable iff (reset)
		(locked_r && wr_option) |=> $stable(cfg_r))
		else $error("locked configuration changed");

	AST_BUS_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
		(on_bus && halted && !cnt_clr) |=> $stable(cnt_r))
		else $error("bus-clock counter moved during halt");

	AST_LPO_HALT_CLEAR: assert property (@(posedge ref_clk) disable iff (reset)
		(!on_bus && halted) |=> cnt_r == '0)
		else $error("slow-oscillator counter not cleared in halt");

	AST_DEBUG_NO_FLAG: assert property (@(posedge ref_clk) disable iff (reset)
		(rst_src == 6'h01 && !wdog_rst_r) |=> cause_r == '0)
		else $error("debug reset left a cause flag");

	AST_CAUSE_WDOG: assert property (@(posedge ref_clk) disable iff (reset)
		(sys_reset_req && rst_src == '0) |=> cause_r == 6'h08)
		else $error("watchdog cause not recorded alone");
endmodule

`default_nettype wire

//--- tb/wdr_watchdog_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdr_regs.svh"

module wdr_watchdog_bench;
	import wdr_pkg::*;

	localparam int T_BUS1 = 32'h2000;

	logic        ref_clk;
	logic        reset;
	logic        s_awvalid;
	logic        s_awready;
	logic        s_wvalid;
	logic        s_wready;
	logic        s_bvalid;
	logic        s_bready;
	logic [1:0]  s_bresp;
	logic        s_arvalid;
	logic        s_arready;
	logic        s_rvalid;
	logic        s_rready;
	wdr_axaddr_t s_aw;
	wdr_axaddr_t s_ar;
	wdr_wdata_t  s_w;
	wdr_rdata_t  s_r;
	logic        low_power_osc;
	logic        debug_halt;
	logic        stop_mode;
	wdr_src_t    rst_src;
	logic        sys_reset_req;
	int          cyc = 0;
	int          n_pulse = 0;
	int          pulse_at = 0;
	int          fails = 0;
	int          n_compared = 0;
	int          p0;
	int          s_at;
	int          h0;
	logic [31:0] d;
	logic [1:0]  resp;
	logic [5:0]  src_v [6] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01};
	logic [5:0]  cause_v [6] = '{6'h20, 6'h10, 6'h04, 6'h02, 6'h01, 6'h00};

	wdr_watchdog DUT (
		.ref_clk       (ref_clk),
		.reset         (reset),
		.s_awvalid     (s_awvalid),
		.s_awready     (s_awready),
		.s_aw          (s_aw),
		.s_wvalid      (s_wvalid),
		.s_wready      (s_wready),
		.s_w           (s_w),
		.s_bvalid      (s_bvalid),
		.s_bready      (s_bready),
		.s_bresp       (s_bresp),
		.s_arvalid     (s_arvalid),
		.s_arready     (s_arready),
		.s_ar          (s_ar),
		.s_rvalid      (s_rvalid),
		.s_rready      (s_rready),
		.s_r           (s_r),
		.low_power_osc (low_power_osc),
		.debug_halt    (debug_halt),
		.stop_mode     (stop_mode),
		.rst_src       (rst_src),
		.sys_reset_req (sys_reset_req)
	);

	// 20 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// Pulse monitor; the ceiling sits well above the longest path of the run
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (sys_reset_req === 1'b1) begin
			n_pulse <= n_pulse + 1;
			pulse_at <= cyc;
		end
		if (cyc == 90000) begin
			fails = fails + 1;
			end_of_test();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
		@(posedge ref_clk);
		s_aw <= '{addr: a, prot: 3'h0};
		s_w <= '{data: v, strb: 4'hF};
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_awvalid && s_awready) s_awvalid <= 1'b0;
			if (s_wvalid && s_wready) s_wvalid <= 1'b0;
		end while (s_bvalid !== 1'b1);
		r = s_bresp;
		s_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		@(posedge ref_clk);
		s_ar <= '{addr: a, prot: 3'h0};
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_arvalid && s_arready) s_arvalid <= 1'b0;
		end while (s_rvalid !== 1'b1);
		v = s_r.data;
		r = s_r.resp;
		s_rready <= 1'b0;
	endtask

	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] v;
		logic [1:0]  r;
		rd(a, v, r);
		check(what, v & m, e);
	endtask

	// Service write; remembers the edge at which the answer was seen
	task automatic svc();
		wr(`WDR_OFF_CAUSE, 32'h000000A5, resp);
		s_at = cyc;
	endtask

	task automatic do_reset();
		reset <= 1'b1;
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
	endtask

	// Slow oscillator edges, far faster than 1 kHz to keep the run short
	task automatic lpo(input int n);
		repeat (n) begin
			repeat (5) @(posedge ref_clk);
			low_power_osc <= 1'b1;
			repeat (5) @(posedge ref_clk);
			low_power_osc <= 1'b0;
		end
	endtask

	task automatic wait_pulse(input int p);
		do @(posedge ref_clk); while (n_pulse == p);
	endtask

	initial begin
		reset = 1'b1;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
		s_aw = '0;
		s_ar = '0;
		s_w = '0;
		{low_power_osc, debug_halt, stop_mode} = 3'h0;
		rst_src = '0;
		do_reset();
		@(posedge ref_clk) rst_src <= 6'h20;
		@(posedge ref_clk) rst_src <= 6'h00;
		// Defaults, cause record, service address and an unmapped place
		rdchk("option", `WDR_OFF_OPTION, 32'h1F, 32'h0C);
		rdchk("cause", `WDR_OFF_CAUSE, 32'h3F, 32'h20);
		wr(`WDR_OFF_CAUSE, 32'hFFFFFFFF, resp);
		check("service resp", resp, `WDR_RESP_OKAY);
		rdchk("cause kept", `WDR_OFF_CAUSE, 32'h3F, 32'h20);
		wr(8'h0C, 32'h1, resp);
		check("unmapped wr resp", resp, `WDR_RESP_SLVERR);
		rd(8'h0C, d, resp);
		check("unmapped rd", {d[29:0], resp}, `WDR_RESP_SLVERR);
		// Default timeout of 1024 oscillator counts
		p0 = n_pulse;
		lpo(1023);
		check("no early overflow", n_pulse, p0);
		lpo(1);
		repeat (3) @(posedge ref_clk);
		check("overflow slow", n_pulse, p0 + 1);
		rdchk("cause wdog", `WDR_OFF_CAUSE, 32'h3F, 32'h08);
		for (int i = 0; i < 6; i++) begin
			@(posedge ref_clk) rst_src <= src_v[i];
			@(posedge ref_clk) rst_src <= 6'h00;
			rdchk("cause src", `WDR_OFF_CAUSE, 32'h3F, {26'h0, cause_v[i]});
		end
		// Bus clock, shortest timeout, lock, then a pause by halt and stop
		wr(`WDR_OFF_OPTION, 32'h6, resp);
		rdchk("option locked", `WDR_OFF_OPTION, 32'h1F, 32'h16);
		wr(`WDR_OFF_OPTION, 32'h0, resp);
		rdchk("second write ignored", `WDR_OFF_OPTION, 32'h1F, 32'h16);
		p0 = n_pulse;
		svc();
		repeat (100) @(posedge ref_clk);
		debug_halt <= 1'b1;
		h0 = cyc;
		rd(`WDR_OFF_COUNT, d, resp);
		repeat (400) @(posedge ref_clk);
		stop_mode <= 1'b1;
		@(posedge ref_clk) debug_halt <= 1'b0;
		repeat (400) @(posedge ref_clk);
		rdchk("count held", `WDR_OFF_COUNT, 32'h3FFFF, d & 32'h3FFFF);
		stop_mode <= 1'b0;
		h0 = cyc - h0;
		wait_pulse(p0);
		check("bus overflow", pulse_at - s_at - h0, T_BUS1);
		// Windowed: early service resets at once, late one restarts the count
		do_reset();
		wr(`WDR_OFF_OPTION, 32'h7, resp);
		p0 = n_pulse;
		svc();
		repeat (3) @(posedge ref_clk);
		check("early service", n_pulse, p0 + 1);
		do rd(`WDR_OFF_COUNT, d, resp); while (d[17:0] < 18'h01838);
		p0 = n_pulse;
		svc();
		repeat (5) @(posedge ref_clk);
		check("service in window", n_pulse, p0);
		wait_pulse(p0);
		check("window restart", pulse_at - s_at, T_BUS1);
		// Timeout select zero never resets
		do_reset();
		wr(`WDR_OFF_OPTION, 32'h2, resp);
		p0 = n_pulse;
		repeat (9000) @(posedge ref_clk);
		check("disabled", n_pulse, p0);
		// Slow clock, middle timeout of 256 counts
		do_reset();
		wr(`WDR_OFF_OPTION, 32'h8, resp);
		p0 = n_pulse;
		lpo(255);
		check("slow no early 256", n_pulse, p0);
		lpo(1);
		repeat (3) @(posedge ref_clk);
		check("slow overflow 256", n_pulse, p0 + 1);
		// Slow clock ignores the window; stop clears the count
		do_reset();
		wr(`WDR_OFF_OPTION, 32'h5, resp);
		p0 = n_pulse;
		svc();
		lpo(20);
		stop_mode <= 1'b1;
		lpo(2);
		rdchk("count cleared", `WDR_OFF_COUNT, 32'h3FFFF, 32'h0);
		stop_mode <= 1'b0;
		lpo(31);
		check("slow no window", n_pulse, p0);
		lpo(1);
		repeat (3) @(posedge ref_clk);
		check("slow overflow 32", n_pulse, p0 + 1);
		end_of_test();
	end
endmodule
`default_nettype wire
